// file: bench/oftr_link_props.sv
// link-level assertions between the readout end and the chip end
module oftr_link_props (
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic clk_tick,
  input wire logic cfg_bit,
  input wire logic cfg_frame,
  input wire logic [oftr_pkg::OFTR_DATA_LINKS-1:0] dat_valid,
  input wire logic [oftr_pkg::OFTR_DATA_LINKS-1:0][oftr_pkg::OFTR_WORD_W-1:0] dat,
  input wire logic [oftr_pkg::OFTR_DATA_LINKS-1:0] dat_par,
  input wire logic st_valid,
  input wire oftr_pkg::oftr_kind_e st_kind,
  input wire logic [oftr_pkg::OFTR_WORD_W-1:0] st_word,
  input wire logic st_par
);
  import oftr_pkg::*;
  // ********
  // helpers
  // ********
  logic [4:0] frm_cnt_reg;
  logic [7:0] tmp_gap_reg;
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_NRST);
  // counts frame cycles already seen, so the fall cycle reads the full length
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST || !cfg_frame) begin
      frm_cnt_reg <= 5'h00;
    end else begin
      frm_cnt_reg <= frm_cnt_reg + 5'h01;
    end
  end
  // saturates so a dead status link cannot wrap back into range
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST || (st_valid && st_kind == OFTR_ST_TEMP)) begin
      tmp_gap_reg <= 8'h00;
    end else if (tmp_gap_reg != 8'hFF) begin
      tmp_gap_reg <= tmp_gap_reg + 8'h01;
    end
  end
  // ********
  // checks
  // ********
  frame_len_max_a: assert property (cfg_frame |-> frm_cnt_reg <= 5'h0F)
    else $error("config frame longer than 16 cycles");
  frame_len_full_a: assert property ($fell(cfg_frame) |-> frm_cnt_reg == 5'h10)
    else $error("config frame shorter than 16 cycles");
  clk_tick_rate_a: assert property (clk_tick |=> !clk_tick [*3] ##1 clk_tick)
    else $error("clock link tick not every 4 cycles");
  lane0_parity_a: assert property (dat_valid[0] |-> dat_par[0] == ^dat[0])
    else $error("lane 0 parity wrong");
  lane1_parity_a: assert property (dat_valid[1] |-> dat_par[1] == ^dat[1])
    else $error("lane 1 parity wrong");
  status_parity_a: assert property (st_valid |-> st_par == ^st_word)
    else $error("status parity wrong");
  status_kind_a: assert property (st_valid |-> st_kind != OFTR_ST_BAD)
    else $error("status kind illegal");
  cfg_ack_a: assert property ($fell(cfg_frame) |-> ##[1:4] (st_valid && st_kind == OFTR_ST_ACK))
    else $error("no acknowledge after config frame");
  cfg_readback_a: assert property ($fell(cfg_frame) |-> ##[2:6] (st_valid && st_kind == OFTR_ST_RDBK))
    else $error("no read-back after config frame");
  temp_gap_a: assert property (tmp_gap_reg <= 8'h50)
    else $error("temperature status missing too long");
endmodule : oftr_link_props

// file: bench/oftr_tb_top.sv
// self-checking bench: readout end and chip end joined over one link
module oftr_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import oftr_pkg::*;
  localparam int unsigned LAT = 20;
  logic clk_sys, nrst, trig, cfg_valid, err_clear, cfg_ready, verify_ok, verify_err;
  logic stat_valid, consist_err, interlock, throttle, err_flag, chip_load, trig_tag_valid;
  logic [7:0] trig_tag, ts_mon;
  logic [1:0] stat_kind, eth_ready, eth_valid, hit_valid;
  logic [OFTR_DATA_LINKS-1:0][OFTR_WORD_W-1:0] hit_data;
  logic [15:0] cfg_word, stat_word, eth_data, chip_word, temp, cfg_shift;
  logic [15:0] eth_q[$];
  logic [1:0] lane_q[$];
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  oftr_link_if i_oftr_link_if ();
  oftr_chip_end i_oftr_chip_end (.I_CLK_SYS(clk_sys), .I_NRST(nrst), .LINK(i_oftr_link_if), .I_HIT_VALID(hit_valid),
    .I_HIT_DATA(hit_data), .I_TEMP(temp), .O_CFG_WORD(chip_word), .O_CFG_LOAD(chip_load));
  oftr_readout_end #(.LATENCY(LAT), .TS_W(8)) i_oftr_readout_end (.I_CLK_SYS(clk_sys), .I_NRST(nrst),
    .LINK(i_oftr_link_if), .I_TRIG(trig), .I_TRIG_TAG_VALID(trig_tag_valid), .I_TRIG_TAG(trig_tag),
    .I_CFG_VALID(cfg_valid),
    .O_CFG_READY(cfg_ready), .I_CFG_WORD(cfg_word), .O_VERIFY_OK(verify_ok), .O_VERIFY_ERR(verify_err),
    .O_STAT_VALID(stat_valid), .O_STAT_KIND(stat_kind), .O_STAT_WORD(stat_word), .O_CONSIST_ERR(consist_err),
    .I_TEMP_LO(16'h0064), .I_TEMP_HI(16'h00C8), .O_INTERLOCK(interlock), .O_THROTTLE(throttle),
    .O_ERROR(err_flag), .I_ERR_CLEAR(err_clear), .O_ETH_VALID(eth_valid), .I_ETH_READY(eth_ready),
    .O_ETH_DATA(eth_data));
  oftr_link_props i_oftr_link_props (.I_CLK_SYS(clk_sys), .I_NRST(nrst), .clk_tick(i_oftr_link_if.clk_tick),
    .cfg_bit(i_oftr_link_if.cfg_bit), .cfg_frame(i_oftr_link_if.cfg_frame), .dat_valid(i_oftr_link_if.dat_valid),
    .dat(i_oftr_link_if.dat), .dat_par(i_oftr_link_if.dat_par), .st_valid(i_oftr_link_if.st_valid),
    .st_kind(i_oftr_link_if.st_kind), .st_word(i_oftr_link_if.st_word), .st_par(i_oftr_link_if.st_par));
  // ********
  // clock, monitors and tasks
  // ********
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    // ring timestamp: one slot per clock, zero in reset
    ts_mon <= nrst ? ts_mon + 8'h01 : 8'h00;
    if (i_oftr_link_if.cfg_frame) cfg_shift <= {cfg_shift[14:0], i_oftr_link_if.cfg_bit};
    for (int k = 0; k < 2; k++) begin
      if (eth_valid[k] && eth_ready[k]) begin
        eth_q.push_back(eth_data);
        lane_q.push_back(2'(k));
      end
    end
    // whole run is under two thousand cycles; a hang is stopped at cycle 20000, far above that
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic do_reset(input int n);
    nrst <= 1'b0;
    tick(n);
    check("interlock", 16'(interlock), 16'h0001);
    check("throttle", 16'(throttle), 16'h0000);
    check("error", 16'(err_flag), 16'h0000);
    check("eth valid", 16'(eth_valid), 16'h0000);
    check("cfg ready", 16'(cfg_ready), 16'h0001);
    nrst <= 1'b1;
    tick(2);
  endtask : do_reset
  task automatic send_cfg(input logic [15:0] w);
    cfg_valid <= 1'b1;
    cfg_word <= w;
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_sys);
      if (cfg_ready === 1'b1) break;
    end
    cfg_valid <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (verify_ok === 1'b1 || verify_err === 1'b1) break;
    end
    check("verify ok", 16'(verify_ok), 16'h0001);
    check("verify err", 16'(verify_err), 16'h0000);
    check("stat kind", 16'(stat_kind), 16'h0002);
    check("readback", stat_word, w);
    check("wire bits", cfg_shift, w);
    check("chip word", chip_word, w);
  endtask : send_cfg
  task automatic temp_case(input logic [15:0] t, input logic exp_il);
    temp <= t;
    for (int i = 0; i < 300 && interlock !== exp_il; i++) @(posedge clk_sys);
    check("interlock", 16'(interlock), 16'(exp_il));
    for (int i = 0; i < 100 && !(stat_valid === 1'b1 && stat_kind === 2'b00); i++) @(posedge clk_sys);
    check("temp word", stat_word, t);
  endtask : temp_case
  task automatic hits(input logic [1:0] v, input logic [15:0] d0, input logic [15:0] d1);
    hit_valid <= v;
    hit_data[0] <= d0;
    hit_data[1] <= d1;
    @(posedge clk_sys);
  endtask : hits
  task automatic pulse_trig(input int gap);
    trig <= 1'b1;
    tick(1);
    trig <= 1'b0;
    tick(gap);
  endtask : pulse_trig
  task automatic drain(input int n);
    int got;
    got = 0;
    eth_ready <= 2'b11;
    for (int i = 0; i < 200 && got < n; i++) begin
      @(posedge clk_sys);
      if (|(eth_valid & eth_ready)) got++;
    end
    eth_ready <= 2'b00;
  endtask : drain
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // ********
  // main sequence
  // ********
  initial begin
    nrst = 1'b0;
    trig = 1'b0;
    trig_tag_valid = 1'b0;
    trig_tag = 8'h00;
    cfg_valid = 1'b0;
    err_clear = 1'b0;
    cfg_word = 16'h0000;
    eth_ready = 2'b11;
    hit_valid = 2'b00;
    hit_data = '0;
    temp = 16'h0096;
    do_reset(6);
    send_cfg(16'hA5C3);
    send_cfg(16'h0001);
    send_cfg(16'hFFFE);
    $display("test config done");
    temp_case(16'h0096, 1'b0);
    temp_case(16'h00FA, 1'b1);
    temp_case(16'h0096, 1'b0);
    temp_case(16'h0032, 1'b1);
    temp_case(16'h0096, 1'b0);
    $display("test interlock done");
    // decoys sit five slots either side, clear of the three-slot window
    eth_q.delete();
    lane_q.delete();
    hits(2'b11, 16'h0BAD, 16'h0BAD);
    hits(2'b00, 16'h0000, 16'h0000);
    tick(3);
    hits(2'b11, 16'h1111, 16'h2222);
    hits(2'b00, 16'h0000, 16'h0000);
    tick(3);
    hits(2'b11, 16'h0BAD, 16'h0BAD);
    hits(2'b00, 16'h0000, 16'h0000);
    tick(LAT - 5);
    pulse_trig(30);
    check("window count", 16'(eth_q.size()), 16'h0002);
    check("word 0", eth_q[0], 16'h1111);
    check("word 1", eth_q[1], 16'h2222);
    check("lane 0", 16'(lane_q[0]), 16'h0000);
    check("lane 1", 16'(lane_q[1]), 16'h0001);
    check("no loss", 16'(err_flag), 16'h0000);
    $display("test window done");
    eth_q.delete();
    lane_q.delete();
    eth_ready <= 2'b00;
    for (int i = 0; i < 30; i++) hits(2'b11, 16'(i), 16'(i + 16'h0100));
    hits(2'b00, 16'h0000, 16'h0000);
    pulse_trig(11);
    pulse_trig(15);
    check("throttle set", 16'(throttle), 16'h0001);
    drain(5);
    tick(3);
    check("throttle held", 16'(throttle), 16'h0001);
    drain(7);
    tick(3);
    check("throttle free", 16'(throttle), 16'h0000);
    check("burst count", 16'(eth_q.size()), 16'h000C);
    for (int j = 0; j < 12; j++) check("lane turn", 16'(lane_q[j]), 16'(j % 2));
    for (int j = 0; j < 6; j++) check("slot pair", eth_q[2 * j + 1], eth_q[2 * j] + 16'h0100);
    for (int j = 1; j < 6; j++) begin
      if (j != 3) check("slot run", eth_q[2 * j], eth_q[2 * j - 2] + 16'h0001);
    end
    check("fixed latency", eth_q[6], eth_q[0] + 16'h000C);
    $display("test throttle done");
    // pending is cleared once reading starts, so only a third trigger finds one waiting
    pulse_trig(1);
    pulse_trig(1);
    pulse_trig(10);
    check("error set", 16'(err_flag), 16'h0001);
    eth_ready <= 2'b11;
    err_clear <= 1'b1;
    tick(1);
    err_clear <= 1'b0;
    tick(20);
    check("error clear", 16'(err_flag), 16'h0000);
    check("consistency", 16'(consist_err), 16'h0000);
    $display("test error done");
    // the hit lands two slots on; forty cycles later only the tag can reach it
    eth_q.delete();
    trig_tag <= ts_mon + 8'h02;
    hits(2'b01, 16'h7E57, 16'h0000);
    hits(2'b00, 16'h0000, 16'h0000);
    tick(40);
    trig_tag_valid <= 1'b1;
    pulse_trig(20);
    check("tag count", 16'(eth_q.size()), 16'h0001);
    check("tag word", eth_q[0], 16'h7E57);
    $display("test tag done");
    do_reset(2);
    $display("test reset done");
    complete_run();
  end
endmodule : oftr_tb_top

// file: pkg/oftr_link_if.sv
// link between the readout and one front-end chip
interface oftr_link_if;
  import oftr_pkg::*;
  logic clk_tick;
  logic cfg_bit;
  logic cfg_frame;
  logic [OFTR_DATA_LINKS-1:0] dat_valid;
  logic [OFTR_DATA_LINKS-1:0][OFTR_WORD_W-1:0] dat;
  logic [OFTR_DATA_LINKS-1:0] dat_par;
  logic st_valid;
  oftr_kind_e st_kind;
  logic [OFTR_WORD_W-1:0] st_word;
  logic st_par;
  modport readout (output clk_tick, output cfg_bit, output cfg_frame,
                   input dat_valid, input dat, input dat_par,
                   input st_valid, input st_kind, input st_word, input st_par);
  modport chip (input clk_tick, input cfg_bit, input cfg_frame,
                output dat_valid, output dat, output dat_par,
                output st_valid, output st_kind, output st_word, output st_par);
endinterface : oftr_link_if

// file: pkg/oftr_pkg.sv
// shared constants and types for the off-detector readout and its front-end chip end
package oftr_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned OFTR_CLK_HZ = 40_000_000;
  localparam int unsigned OFTR_CLK_PERIOD_PS = 25_000;
  localparam int unsigned OFTR_WINDOW_NS = 75;
  // least time, rounded up to whole cycles
  localparam int unsigned OFTR_WINDOW_CYC = (OFTR_WINDOW_NS * 1000 + OFTR_CLK_PERIOD_PS - 1) / OFTR_CLK_PERIOD_PS;
  localparam int unsigned OFTR_WINDOW_HALF = OFTR_WINDOW_CYC / 2;
  localparam int unsigned OFTR_LATENCY_US = 1000;
  localparam int unsigned OFTR_LATENCY_CYC = OFTR_LATENCY_US * (OFTR_CLK_HZ / 1_000_000);
  localparam int unsigned OFTR_CLK_LINK_DIV = 4;
  localparam int unsigned OFTR_TEMP_PERIOD = 16;

  // ************************************************************
  // widths and sizes
  // ************************************************************
  localparam int unsigned OFTR_WORD_W = 16;
  localparam int unsigned OFTR_TS_W = 16;
  localparam int unsigned OFTR_DATA_LINKS = 2;
  localparam int unsigned OFTR_ETH_LINKS = 2;
  localparam int unsigned OFTR_FIFO_DEPTH = 16;
  localparam int unsigned OFTR_THR_HI = 12;
  localparam int unsigned OFTR_THR_LO = 4;

  typedef enum logic [1:0] {
    OFTR_ST_TEMP = 2'b00,
    OFTR_ST_ACK = 2'b01,
    OFTR_ST_RDBK = 2'b10,
    OFTR_ST_BAD = 2'b11
  } oftr_kind_e;

  function automatic logic oftr_parity(input logic [OFTR_WORD_W-1:0] w);
    oftr_parity = ^w;
  endfunction : oftr_parity
endpackage : oftr_pkg

// file: verilog/oftr_chip_end.sv
// front-end chip end: data links, status link, configuration receiver
module oftr_chip_end (
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  oftr_link_if.chip LINK,
  input wire logic [oftr_pkg::OFTR_DATA_LINKS-1:0] I_HIT_VALID,
  input wire logic [oftr_pkg::OFTR_DATA_LINKS-1:0][oftr_pkg::OFTR_WORD_W-1:0] I_HIT_DATA,
  input wire logic [oftr_pkg::OFTR_WORD_W-1:0] I_TEMP,
  output logic [oftr_pkg::OFTR_WORD_W-1:0] O_CFG_WORD,
  output logic O_CFG_LOAD
);
  import oftr_pkg::*;

  logic [OFTR_WORD_W-1:0] cfg_sh_reg;
  logic frame_d_reg;
  logic ack_pend_reg;
  logic rdbk_pend_reg;
  logic [4:0] temp_cnt_reg;
  logic temp_pend_reg;
  logic cfg_done;

  // ************************************************************
  // data links
  // ************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      LINK.dat_valid <= '0;
      LINK.dat <= '0;
      LINK.dat_par <= '0;
    end else begin
      LINK.dat_valid <= I_HIT_VALID;
      LINK.dat <= I_HIT_DATA;
      for (int i = 0; i < OFTR_DATA_LINKS; i++) begin
        LINK.dat_par[i] <= oftr_parity(I_HIT_DATA[i]);
      end
    end
  end

  // ************************************************************
  // configuration receiver
  // ************************************************************
  assign cfg_done = frame_d_reg && !LINK.cfg_frame;

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      cfg_sh_reg <= '0;
      frame_d_reg <= 1'b0;
      O_CFG_WORD <= '0;
      O_CFG_LOAD <= 1'b0;
    end else begin
      frame_d_reg <= LINK.cfg_frame;
      O_CFG_LOAD <= cfg_done;
      if (LINK.cfg_frame) begin
        cfg_sh_reg <= {cfg_sh_reg[OFTR_WORD_W-2:0], LINK.cfg_bit};
      end
      if (cfg_done) begin
        O_CFG_WORD <= cfg_sh_reg;
      end
    end
  end

  // ************************************************************
  // status link: ack first, then read-back, then temperature
  // ************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      temp_cnt_reg <= '0;
      temp_pend_reg <= 1'b0;
    end else begin
      if (LINK.clk_tick) begin
        temp_cnt_reg <= (temp_cnt_reg == 5'(OFTR_TEMP_PERIOD - 1)) ? '0 : temp_cnt_reg + 5'h01;
      end
      if (LINK.clk_tick && temp_cnt_reg == '0) begin
        temp_pend_reg <= 1'b1;
      end else if (!ack_pend_reg && !rdbk_pend_reg) begin
        temp_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      ack_pend_reg <= 1'b0;
      rdbk_pend_reg <= 1'b0;
      LINK.st_valid <= 1'b0;
      LINK.st_kind <= OFTR_ST_TEMP;
      LINK.st_word <= '0;
      LINK.st_par <= 1'b0;
    end else begin
      LINK.st_valid <= 1'b0;
      if (ack_pend_reg) begin
        ack_pend_reg <= 1'b0;
        rdbk_pend_reg <= 1'b1;
        LINK.st_valid <= 1'b1;
        LINK.st_kind <= OFTR_ST_ACK;
        LINK.st_word <= '0;
        LINK.st_par <= 1'b0;
      end else if (rdbk_pend_reg) begin
        rdbk_pend_reg <= 1'b0;
        LINK.st_valid <= 1'b1;
        LINK.st_kind <= OFTR_ST_RDBK;
        LINK.st_word <= O_CFG_WORD;
        LINK.st_par <= oftr_parity(O_CFG_WORD);
      end else if (temp_pend_reg) begin
        LINK.st_valid <= 1'b1;
        LINK.st_kind <= OFTR_ST_TEMP;
        LINK.st_word <= I_TEMP;
        LINK.st_par <= oftr_parity(I_TEMP);
      end
      // a new frame end always wins over the pending work just served
      if (O_CFG_LOAD) begin
        ack_pend_reg <= 1'b1;
      end
    end
  end
endmodule : oftr_chip_end

// file: verilog/oftr_readout_end.sv
// off-detector readout end: trigger buffer, selection, output fifo, status, config, interlock
module oftr_fifo #(
  parameter int unsigned WIDTH = oftr_pkg::OFTR_WORD_W,
  parameter int unsigned DEPTH = oftr_pkg::OFTR_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic push;
  logic pop;

  assign o_ready = (o_count != (AW+1)'(DEPTH));
  assign o_valid = (o_count != '0);
  assign o_data = mem[rd_reg];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_reg] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      o_count <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
      end
      o_count <= o_count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : oftr_fifo

module oftr_readout_end #(
  parameter int unsigned LATENCY = oftr_pkg::OFTR_LATENCY_CYC,
  parameter int unsigned TS_W = oftr_pkg::OFTR_TS_W,
  parameter int unsigned FIFO_DEPTH = oftr_pkg::OFTR_FIFO_DEPTH,
  parameter int unsigned THR_HI = oftr_pkg::OFTR_THR_HI,
  parameter int unsigned THR_LO = oftr_pkg::OFTR_THR_LO
) (
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  oftr_link_if.readout LINK,
  input wire logic I_TRIG,
  input wire logic I_TRIG_TAG_VALID,
  input wire logic [TS_W-1:0] I_TRIG_TAG,
  input wire logic I_CFG_VALID,
  output logic O_CFG_READY,
  input wire logic [oftr_pkg::OFTR_WORD_W-1:0] I_CFG_WORD,
  output logic O_VERIFY_OK,
  output logic O_VERIFY_ERR,
  output logic O_STAT_VALID,
  output logic [1:0] O_STAT_KIND,
  output logic [oftr_pkg::OFTR_WORD_W-1:0] O_STAT_WORD,
  output logic O_CONSIST_ERR,
  input wire logic [oftr_pkg::OFTR_WORD_W-1:0] I_TEMP_LO,
  input wire logic [oftr_pkg::OFTR_WORD_W-1:0] I_TEMP_HI,
  output logic O_INTERLOCK,
  output logic O_THROTTLE,
  output logic O_ERROR,
  input wire logic I_ERR_CLEAR,
  output logic [oftr_pkg::OFTR_ETH_LINKS-1:0] O_ETH_VALID,
  input wire logic [oftr_pkg::OFTR_ETH_LINKS-1:0] I_ETH_READY,
  output logic [oftr_pkg::OFTR_WORD_W-1:0] O_ETH_DATA
);
  import oftr_pkg::*;

  localparam int unsigned RW = OFTR_DATA_LINKS * (OFTR_WORD_W + 1);
  localparam int unsigned FCW = $clog2(FIFO_DEPTH) + 1;

  typedef enum logic [1:0] {
    OFTR_SEL_IDLE = 2'b00,
    OFTR_SEL_READ = 2'b01
  } oftr_sel_e;

  // ************************************************************
  // trigger-wait ring, one slot per clock, indexed by timestamp
  // ************************************************************
  // depth 2**TS_W must exceed LATENCY + window; raise TS_W for longer latency
  logic [RW-1:0] ring_mem [2**TS_W];
  logic [TS_W-1:0] ts_reg;
  logic [RW-1:0] slot;

  always_comb begin
    slot = '0;
    for (int i = 0; i < OFTR_DATA_LINKS; i++) begin
      slot[i*(OFTR_WORD_W+1) +: OFTR_WORD_W+1] = {LINK.dat_valid[i], LINK.dat[i]};
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    ring_mem[ts_reg] <= slot;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      ts_reg <= '0;
    end else begin
      ts_reg <= ts_reg + TS_W'(1);
    end
  end

  // ************************************************************
  // selection of the window around the event
  // ************************************************************
  oftr_sel_e sel_reg;
  logic [TS_W-1:0] rd_ptr_reg;
  logic [$clog2(OFTR_WINDOW_CYC):0] rd_left_reg;
  logic [$clog2(OFTR_DATA_LINKS+1)-1:0] lane_idx_reg;
  logic pend_reg;
  logic [TS_W-1:0] pend_ts_reg;
  logic [TS_W-1:0] trig_ev;
  logic [RW-1:0] rd_slot;
  logic cur_valid;
  logic [OFTR_WORD_W-1:0] cur_data;
  logic slot_ready;
  logic fifo_in_ready;
  logic fifo_push;
  logic advance;
  logic overrun;
  logic lost;
  logic cons_bad;

  // constant latency: event is LATENCY slots back; tag overrides when latency varies
  assign trig_ev = I_TRIG_TAG_VALID ? I_TRIG_TAG : ts_reg - TS_W'(LATENCY);
  assign rd_slot = ring_mem[rd_ptr_reg];
  assign cur_valid = rd_slot[lane_idx_reg*(OFTR_WORD_W+1) + OFTR_WORD_W];
  assign cur_data = rd_slot[lane_idx_reg*(OFTR_WORD_W+1) +: OFTR_WORD_W];
  assign slot_ready = (rd_ptr_reg != ts_reg);
  assign fifo_push = (sel_reg == OFTR_SEL_READ) && slot_ready && cur_valid;
  assign advance = (sel_reg == OFTR_SEL_READ) && slot_ready && (!cur_valid || fifo_in_ready);
  // the slot under the read pointer is the next one the ring overwrites
  assign overrun = (sel_reg == OFTR_SEL_READ) && (rd_ptr_reg == ts_reg + TS_W'(1));
  assign lost = overrun || (I_TRIG && pend_reg);

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      pend_reg <= 1'b0;
      pend_ts_reg <= '0;
    end else begin
      if (I_TRIG && !pend_reg) begin
        pend_reg <= 1'b1;
        pend_ts_reg <= trig_ev - TS_W'(OFTR_WINDOW_HALF);
      end else if (sel_reg == OFTR_SEL_IDLE) begin
        pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      sel_reg <= OFTR_SEL_IDLE;
      rd_ptr_reg <= '0;
      rd_left_reg <= '0;
      lane_idx_reg <= '0;
    end else begin
      unique case (sel_reg)
        OFTR_SEL_IDLE: begin
          if (pend_reg) begin
            sel_reg <= OFTR_SEL_READ;
            rd_ptr_reg <= pend_ts_reg;
            rd_left_reg <= ($clog2(OFTR_WINDOW_CYC)+1)'(OFTR_WINDOW_CYC);
            lane_idx_reg <= '0;
          end
        end
        OFTR_SEL_READ: begin
          if (overrun) begin
            sel_reg <= OFTR_SEL_IDLE;
          end else if (advance) begin
            if (lane_idx_reg == $bits(lane_idx_reg)'(OFTR_DATA_LINKS - 1)) begin
              lane_idx_reg <= '0;
              rd_ptr_reg <= rd_ptr_reg + TS_W'(1);
              rd_left_reg <= rd_left_reg - 1'b1;
              if (rd_left_reg == ($clog2(OFTR_WINDOW_CYC)+1)'(1)) begin
                sel_reg <= OFTR_SEL_IDLE;
              end
            end else begin
              lane_idx_reg <= lane_idx_reg + 1'b1;
            end
          end
        end
        default: sel_reg <= OFTR_SEL_IDLE;
      endcase
    end
  end

  // ************************************************************
  // output fifo and two ethernet links, alternating per word
  // ************************************************************
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FCW-1:0] fifo_count;
  logic eth_lane_reg;

  oftr_fifo #(.WIDTH(OFTR_WORD_W), .DEPTH(FIFO_DEPTH)) i_oftr_fifo (
    .i_clk(I_CLK_SYS),
    .i_nrst(I_NRST),
    .i_valid(fifo_push),
    .o_ready(fifo_in_ready),
    .i_data(cur_data),
    .o_valid(fifo_out_valid),
    .i_ready(fifo_out_ready),
    .o_data(O_ETH_DATA),
    .o_count(fifo_count)
  );

  assign fifo_out_ready = I_ETH_READY[eth_lane_reg];
  assign O_ETH_VALID = fifo_out_valid ? (OFTR_ETH_LINKS)'(1) << eth_lane_reg : '0;

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      eth_lane_reg <= 1'b0;
    end else if (fifo_out_valid && fifo_out_ready) begin
      eth_lane_reg <= !eth_lane_reg;
    end
  end

  // ************************************************************
  // throttle and error towards the trigger system
  // ************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      O_THROTTLE <= 1'b0;
      O_ERROR <= 1'b0;
      O_CONSIST_ERR <= 1'b0;
    end else begin
      if (fifo_count >= FCW'(THR_HI) || pend_reg) begin
        O_THROTTLE <= 1'b1;
      end else if (fifo_count < FCW'(THR_LO)) begin
        O_THROTTLE <= 1'b0;
      end
      // a new loss in the clearing cycle keeps the flag set
      if (lost) begin
        O_ERROR <= 1'b1;
      end else if (I_ERR_CLEAR) begin
        O_ERROR <= 1'b0;
      end
      if (cons_bad) begin
        O_CONSIST_ERR <= 1'b1;
      end else if (I_ERR_CLEAR) begin
        O_CONSIST_ERR <= 1'b0;
      end
    end
  end

  // ************************************************************
  // status evaluation, forwarding and interlock
  // ************************************************************
  logic [OFTR_DATA_LINKS-1:0] dat_bad;
  logic st_bad;
  logic [OFTR_WORD_W-1:0] temp_reg;
  logic temp_seen_reg;
  logic [OFTR_WORD_W-1:0] sent_reg;

  always_comb begin
    for (int i = 0; i < OFTR_DATA_LINKS; i++) begin
      dat_bad[i] = LINK.dat_valid[i] && (oftr_parity(LINK.dat[i]) != LINK.dat_par[i]);
    end
  end
  assign st_bad = LINK.st_valid && ((oftr_parity(LINK.st_word) != LINK.st_par) || LINK.st_kind == OFTR_ST_BAD);
  assign cons_bad = (|dat_bad) || st_bad;

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      O_STAT_VALID <= 1'b0;
      O_STAT_KIND <= '0;
      O_STAT_WORD <= '0;
      O_VERIFY_OK <= 1'b0;
      O_VERIFY_ERR <= 1'b0;
      temp_reg <= '0;
      temp_seen_reg <= 1'b0;
      O_INTERLOCK <= 1'b1;
    end else begin
      O_STAT_VALID <= LINK.st_valid && !st_bad;
      O_STAT_KIND <= LINK.st_kind;
      O_STAT_WORD <= LINK.st_word;
      O_VERIFY_OK <= LINK.st_valid && !st_bad && LINK.st_kind == OFTR_ST_RDBK && LINK.st_word == sent_reg;
      O_VERIFY_ERR <= LINK.st_valid && !st_bad && LINK.st_kind == OFTR_ST_RDBK && LINK.st_word != sent_reg;
      if (LINK.st_valid && !st_bad && LINK.st_kind == OFTR_ST_TEMP) begin
        temp_reg <= LINK.st_word;
        temp_seen_reg <= 1'b1;
      end
      // held safe until a first good temperature arrives; no software in this path
      O_INTERLOCK <= !temp_seen_reg || temp_reg < I_TEMP_LO || temp_reg > I_TEMP_HI;
    end
  end

  // ************************************************************
  // clock link and serial configuration link
  // ************************************************************
  logic [$clog2(OFTR_CLK_LINK_DIV)-1:0] div_reg;
  logic [OFTR_WORD_W-1:0] cfg_sh_reg;
  logic [$clog2(OFTR_WORD_W):0] cfg_cnt_reg;

  assign O_CFG_READY = (cfg_cnt_reg == '0);

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      div_reg <= '0;
      LINK.clk_tick <= 1'b0;
    end else begin
      div_reg <= div_reg + 1'b1;
      LINK.clk_tick <= (div_reg == '0);
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      cfg_sh_reg <= '0;
      cfg_cnt_reg <= '0;
      sent_reg <= '0;
      LINK.cfg_bit <= 1'b0;
      LINK.cfg_frame <= 1'b0;
    end else begin
      if (I_CFG_VALID && O_CFG_READY) begin
        cfg_sh_reg <= I_CFG_WORD;
        sent_reg <= I_CFG_WORD;
        cfg_cnt_reg <= ($clog2(OFTR_WORD_W)+1)'(OFTR_WORD_W);
      end else if (cfg_cnt_reg != '0) begin
        LINK.cfg_bit <= cfg_sh_reg[OFTR_WORD_W-1];
        cfg_sh_reg <= {cfg_sh_reg[OFTR_WORD_W-2:0], 1'b0};
        cfg_cnt_reg <= cfg_cnt_reg - 1'b1;
      end
      LINK.cfg_frame <= (cfg_cnt_reg != '0) && !(I_CFG_VALID && O_CFG_READY);
    end
  end
endmodule : oftr_readout_end
